//--- rtl/sees_pkg.sv
// Purpose: constants for the status event and enable summary block
// Assumes: one clock, power-up reset drives rst
// Notes: register set indices and bit widths live here
package sees_pkg;
  // ---------------------------------------------------------------
  // register sets
  // ---------------------------------------------------------------
  localparam int SEES_NUM_SETS = 4;
  localparam int SEES_REG_W = 16;
  localparam logic [1:0] SEES_SET_STD = 2'h0;
  localparam logic [1:0] SEES_SET_OPER = 2'h1;
  localparam logic [1:0] SEES_SET_MEAS = 2'h2;
  localparam logic [1:0] SEES_SET_QUES = 2'h3;
  localparam logic [15:0] SEES_REG_RESET = 16'h0000;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SEES_BATT_BUF_FULL_BIT = 9;
  localparam int SEES_STB_ERR_AVAIL_BIT = 2;
  localparam int SEES_STB_MSS_BIT = 6;
  localparam int SEES_STB_W = 8;
  // summary bit positions of the four sets in the status byte
  localparam int SEES_STB_QUES_BIT = 3;
  localparam int SEES_STB_MEAS_BIT = 0;
  localparam int SEES_STB_STD_BIT = 5;
  localparam int SEES_STB_OPER_BIT = 7;
  localparam int SEES_AVG_CNT_W = 16;
  // ---------------------------------------------------------------
  // buffer fill states
  // ---------------------------------------------------------------
  typedef enum logic [0:0]
  {
    SEES_FILL_IDLE = 1'b0,
    SEES_FILL_RUN = 1'b1
  } sees_fill_type;
endpackage

//--- rtl/sees_event_set.sv
// Purpose: one latched event register with its enable and summary
// Assumes: host strobes are single-cycle pulses
// Notes: enable preset behaviour chosen by parameter
`timescale 1ns/1ps
`default_nettype none
module sees_event_set
  import sees_pkg::*;
#(
  parameter int WIDTH = SEES_REG_W,
  parameter bit PRESET_CLEARS = 1'b1
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // events and commands
  input wire logic [WIDTH-1:0] event_in,
  input wire logic event_read,
  input wire logic clear_status,
  input wire logic status_preset,
  input wire logic enable_write,
  input wire logic [WIDTH-1:0] enable_data,
  // results
  output logic [WIDTH-1:0] event_reg,
  output logic [WIDTH-1:0] enable_reg,
  output logic summary_reg
);
  // ---------------------------------------------------------------
  // next values
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] event_next;
  logic [WIDTH-1:0] enable_next;
  logic summary_next;
  wire clear_event = event_read | clear_status;
  wire preset_hit = status_preset & PRESET_CLEARS;
  // R2: set on event; R3: latch; R4, R5: read or clear-status; R18: set wins
  assign event_next = (clear_event ? {WIDTH{1'b0}} : event_reg) | event_in;
  // R9: write loads value; R10, R11: preset clears
  assign enable_next = enable_write ? enable_data :
                       (preset_hit ? {WIDTH{1'b0}} : enable_reg);
  // R7: and per bit; R17: or over bits every cycle
  assign summary_next = |(event_next & enable_next);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // R6: power-up clears everything
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      event_reg <= WIDTH'(SEES_REG_RESET);
      enable_reg <= WIDTH'(SEES_REG_RESET);
      summary_reg <= 1'b0;
    end
    else
    begin
      event_reg <= event_next;
      enable_reg <= enable_next;
      summary_reg <= summary_next;
    end
  end
  // R18: event in clear cycle survives
  chk_event_not_lost: assert property (@(posedge ref_clk) disable iff (rst) // R18
    (clear_event && (event_in != '0)) |=> ((event_reg & $past(event_in)) == $past(event_in)))
    else $error("event lost during clear");
  // R3: latched bit holds without clear
  chk_event_latch_hold: assert property (@(posedge ref_clk) disable iff (rst) // R3
    !clear_event |=> ((event_reg & $past(event_reg)) == $past(event_reg)))
    else $error("latched event dropped");
  // R8: summary follows enabled events
  chk_summary_match: assert property (@(posedge ref_clk) disable iff (rst) // R8
    summary_reg == |(event_reg & enable_reg))
    else $error("summary mismatch");
  // R10: clear-status leaves enable alone
  chk_cls_keeps_enable: assert property (@(posedge ref_clk) disable iff (rst) // R10
    (clear_status && !enable_write && !status_preset) |=> $stable(enable_reg))
    else $error("clear-status touched enable");
endmodule
`default_nettype wire

//--- rtl/sees_avg_counter.sv
// Purpose: counts averaged readings after a trigger, flags buffer full
// Assumes: reading strobes are one-cycle pulses
// Notes: a trigger while running restarts the count
`timescale 1ns/1ps
`default_nettype none
module sees_avg_counter
  import sees_pkg::*;
#(
  parameter int CNT_W = SEES_AVG_CNT_W
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control
  input wire logic trigger,
  input wire logic reading_done,
  input wire logic [CNT_W-1:0] avg_count,
  // result
  output logic buffer_full_reg
);
  sees_fill_type state_reg;
  sees_fill_type state_next;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic full_next;
  wire [CNT_W-1:0] count_inc = count_reg + CNT_W'(1);
  // zero count treated as one reading
  wire last_reading = (state_reg == SEES_FILL_RUN) && reading_done &&
                      (count_inc >= avg_count);
  // ---------------------------------------------------------------
  // fill control
  // ---------------------------------------------------------------
  // R13: full only after programmed count following trigger
  always_comb
  begin
    state_next = state_reg;
    count_next = count_reg;
    full_next = 1'b0;
    unique case (state_reg)
      SEES_FILL_IDLE:
      begin
        if (trigger)
        begin
          state_next = SEES_FILL_RUN;
          count_next = '0;
        end
      end
      SEES_FILL_RUN:
      begin
        if (trigger)
        begin
          count_next = '0;
        end
        else if (last_reading)
        begin
          state_next = SEES_FILL_IDLE;
          full_next = 1'b1;
        end
        else if (reading_done)
        begin
          count_next = count_inc;
        end
      end
    endcase
  end
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= SEES_FILL_IDLE;
      count_reg <= '0;
      buffer_full_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
      buffer_full_reg <= full_next;
    end
  end
  // R13: full pulse only in the cycle after a reading done in the run state
  chk_full_needs_run: assert property (@(posedge ref_clk) disable iff (rst) // R13
    buffer_full_reg |-> ($past(state_reg) == SEES_FILL_RUN && $past(reading_done)))
    else $error("buffer full without readings");
endmodule
`default_nettype wire

//--- rtl/sees_status_top.sv
// Purpose: event and enable registers of the four status sets, summary bits
// Assumes: command strobes are one-cycle pulses decoded upstream
// Notes: condition registers mirror live inputs, status byte is registered
//
// Function
// R1: four event registers, each with enable register, all readable by host.
// R2: an occurring event sets its event bit to one.
// R3: set event bits stay latched until the register is reset.
// R4: reading an event register returns contents then clears it.
// R5: clear-status resets all four event registers together.
// R6: power-up clears event registers; preset leaves them unchanged.
// R7: each event bit is anded with its enable bit.
// R8: any enabled set event raises the summary bit in the status byte.
// R9: writing zero to an enable register clears all its bits.
// R10: power-up and preset clear enables; clear-status leaves them alone.
// R11: preset leaves the standard event enable register untouched.
// R12: battery buffer full flag sits at measurement bit nine, weight 512.
// R13: buffer full rises only after programmed averaged readings after trigger.
// R14: host fetches buffered data only after seeing buffer full.
// R15: condition registers mirror live conditions, independent of event latches.
// R16: status byte holds master summary on bit six, error available on two.
// R17: summary is or of event and enable bits, recomputed each cycle.
// R18: an event arriving during a read clear stays set.
`timescale 1ns/1ps
`default_nettype none
module sees_status_top
  import sees_pkg::*;
#(
  parameter int WIDTH = SEES_REG_W,
  parameter int CNT_W = SEES_AVG_CNT_W
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // event sources per set
  input wire logic [WIDTH-1:0] std_event_in,
  input wire logic [WIDTH-1:0] oper_event_in,
  input wire logic [WIDTH-1:0] meas_event_in,
  input wire logic [WIDTH-1:0] ques_event_in,
  // live conditions
  input wire logic [WIDTH-1:0] oper_cond_in,
  input wire logic [WIDTH-1:0] meas_cond_in,
  input wire logic [WIDTH-1:0] ques_cond_in,
  // battery channel averaging
  input wire logic buf_trigger,
  input wire logic reading_done,
  input wire logic [CNT_W-1:0] avg_count,
  // host commands
  input wire logic clear_status,
  input wire logic status_preset,
  input wire logic event_read,
  input wire logic enable_write,
  input wire logic [1:0] reg_select,
  input wire logic [WIDTH-1:0] enable_data,
  input wire logic error_available_flag,
  input wire logic [SEES_STB_W-1:0] stb_enable,
  // register contents
  output logic [WIDTH-1:0] std_event_reg,
  output logic [WIDTH-1:0] oper_event_reg,
  output logic [WIDTH-1:0] meas_event_reg,
  output logic [WIDTH-1:0] ques_event_reg,
  output logic [WIDTH-1:0] std_enable_reg,
  output logic [WIDTH-1:0] oper_enable_reg,
  output logic [WIDTH-1:0] meas_enable_reg,
  output logic [WIDTH-1:0] ques_enable_reg,
  output logic [WIDTH-1:0] oper_cond_reg,
  output logic [WIDTH-1:0] meas_cond_reg,
  output logic [WIDTH-1:0] ques_cond_reg,
  // read return and status byte
  output logic [WIDTH-1:0] read_data_reg,
  output logic [SEES_STB_W-1:0] status_byte_reg
);
  // ---------------------------------------------------------------
  // per-set wiring
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] ev_in [SEES_NUM_SETS];
  logic [WIDTH-1:0] ev_q [SEES_NUM_SETS];
  logic [WIDTH-1:0] en_q [SEES_NUM_SETS];
  logic [SEES_NUM_SETS-1:0] summ;
  logic battery_buffer_full_flag;
  logic [WIDTH-1:0] meas_src;
  // R12: buffer full pulse enters measurement bit nine
  assign meas_src = meas_event_in |
                    (WIDTH'(battery_buffer_full_flag) << SEES_BATT_BUF_FULL_BIT);
  assign ev_in[SEES_SET_STD] = std_event_in;
  assign ev_in[SEES_SET_OPER] = oper_event_in;
  assign ev_in[SEES_SET_MEAS] = meas_src;
  assign ev_in[SEES_SET_QUES] = ques_event_in;
  sees_avg_counter #(
    .CNT_W(CNT_W)
  ) u_avg (
    .ref_clk(ref_clk),
    .rst(rst),
    .trigger(buf_trigger),
    .reading_done(reading_done),
    .avg_count(avg_count),
    .buffer_full_reg(battery_buffer_full_flag)
  );
  // R1: one event and enable pair per set
  genvar gi;
  generate
    for (gi = 0; gi < SEES_NUM_SETS; gi++)
    begin : g_set
      wire sel = (reg_select == 2'(gi));
      sees_event_set #(
        .WIDTH(WIDTH),
        // R11: standard enable immune to preset
        .PRESET_CLEARS(gi != SEES_SET_STD)
      ) u_set (
        .ref_clk(ref_clk),
        .rst(rst),
        .event_in(ev_in[gi]),
        .event_read(event_read & sel),
        .clear_status(clear_status),
        .status_preset(status_preset),
        .enable_write(enable_write & sel),
        .enable_data(enable_data),
        .event_reg(ev_q[gi]),
        .enable_reg(en_q[gi]),
        .summary_reg(summ[gi])
      );
    end
  endgenerate
  assign std_event_reg = ev_q[SEES_SET_STD];
  assign oper_event_reg = ev_q[SEES_SET_OPER];
  assign meas_event_reg = ev_q[SEES_SET_MEAS];
  assign ques_event_reg = ev_q[SEES_SET_QUES];
  assign std_enable_reg = en_q[SEES_SET_STD];
  assign oper_enable_reg = en_q[SEES_SET_OPER];
  assign meas_enable_reg = en_q[SEES_SET_MEAS];
  assign ques_enable_reg = en_q[SEES_SET_QUES];
  // ---------------------------------------------------------------
  // read return and status byte
  // ---------------------------------------------------------------
  // R4: read returns content before the clear lands
  wire [WIDTH-1:0] read_next = event_read ? ev_q[reg_select] : read_data_reg;
  logic [SEES_STB_W-1:0] stb_raw;
  logic [SEES_STB_W-1:0] stb_next;
  // R8: set summaries feed status byte bits
  always_comb
  begin
    stb_raw = '0;
    stb_raw[SEES_STB_STD_BIT] = summ[SEES_SET_STD];
    stb_raw[SEES_STB_OPER_BIT] = summ[SEES_SET_OPER];
    stb_raw[SEES_STB_MEAS_BIT] = summ[SEES_SET_MEAS];
    stb_raw[SEES_STB_QUES_BIT] = summ[SEES_SET_QUES];
    // R16: error available on bit two
    stb_raw[SEES_STB_ERR_AVAIL_BIT] = error_available_flag;
    stb_next = stb_raw;
    // R16: master summary on bit six
    stb_next[SEES_STB_MSS_BIT] = |(stb_raw & stb_enable);
  end
  wire master_summary_status = stb_next[SEES_STB_MSS_BIT];
  // R15: condition registers follow live inputs every cycle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      oper_cond_reg <= '0;
      meas_cond_reg <= '0;
      ques_cond_reg <= '0;
      read_data_reg <= '0;
      status_byte_reg <= '0;
    end
    else
    begin
      oper_cond_reg <= oper_cond_in;
      meas_cond_reg <= meas_cond_in;
      ques_cond_reg <= ques_cond_in;
      read_data_reg <= read_next;
      status_byte_reg <= {stb_next[SEES_STB_W-1:SEES_STB_MSS_BIT+1],
                          master_summary_status,
                          stb_next[SEES_STB_MSS_BIT-1:0]};
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // R4: read returns old contents and clears
  chk_read_clears: assert property (@(posedge ref_clk) disable iff (rst) // R4
    (event_read && reg_select == SEES_SET_OPER && oper_event_in == '0)
    |=> (oper_event_reg == '0 && read_data_reg == $past(oper_event_reg)))
    else $error("read did not clear operation events");
  // R5: clear-status empties quiet sets
  chk_cls_clears: assert property (@(posedge ref_clk) disable iff (rst) // R5
    (clear_status && ques_event_in == '0 && std_event_in == '0)
    |=> (ques_event_reg == '0 && std_event_reg == '0))
    else $error("clear-status left events");
  // R11: preset keeps standard enable
  chk_preset_std_keep: assert property (@(posedge ref_clk) disable iff (rst) // R11
    (status_preset && !enable_write) |=> (std_enable_reg == $past(std_enable_reg)
    && oper_enable_reg == '0 && meas_enable_reg == '0))
    else $error("preset enable handling wrong");
  // R6: preset leaves events
  chk_preset_events: assert property (@(posedge ref_clk) disable iff (rst) // R6
    (status_preset && !clear_status && !event_read)
    |=> ((meas_event_reg & $past(meas_event_reg)) == $past(meas_event_reg)))
    else $error("preset changed events");
  // R12: buffer full lands on bit nine
  chk_bf_bit_nine: assert property (@(posedge ref_clk) disable iff (rst) // R12
    battery_buffer_full_flag |=> meas_event_reg[SEES_BATT_BUF_FULL_BIT])
    else $error("buffer full not on bit nine");
  // R9: enable write of zero masks set
  chk_enable_zero: assert property (@(posedge ref_clk) disable iff (rst) // R9
    (enable_write && enable_data == '0 && reg_select == SEES_SET_MEAS)
    |=> meas_enable_reg == '0 ##1 !status_byte_reg[SEES_STB_MEAS_BIT])
    else $error("zero enable did not mask");
  // R16: master summary follows enabled status byte bits
  chk_mss_bit: assert property (@(posedge ref_clk) disable iff (rst) // R16
    status_byte_reg[SEES_STB_MSS_BIT] == |({status_byte_reg[7], 1'b0,
    status_byte_reg[5:0]} & $past(stb_enable)))
    else $error("master summary wrong");
  // R15: condition registers track inputs
  chk_cond_mirror: assert property (@(posedge ref_clk) disable iff (rst) // R15
    !$past(rst) |-> (meas_cond_reg == $past(meas_cond_in)))
    else $error("condition register stale");
  // R2: an event sets its bit
  chk_event_sets: assert property (@(posedge ref_clk) disable iff (rst) // R2
    (std_event_in != '0) |=> ((std_event_reg & $past(std_event_in)) == $past(std_event_in)))
    else $error("standard event not latched");
endmodule
`default_nettype wire

//--- tb/sees_host_model.sv
// Purpose: host controller model issuing status commands to the block
// Assumes: commands change at the falling edge as one-cycle strobes
// Notes: select and data lines show inverted values between commands
`timescale 1ns/1ps
`default_nettype none
module sees_host_model
  import sees_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // command strobes
  output logic clear_status,
  output logic status_preset,
  output logic event_read,
  output logic enable_write,
  output logic [1:0] reg_select,
  output logic [15:0] enable_data,
  // read return
  input wire logic [15:0] read_data_reg
);
  initial
  begin
    {clear_status, status_preset, event_read, enable_write} = 4'h0;
    reg_select = 2'h0;
    enable_data = 16'h0000;
  end
  // kind 0 clear, 1 preset, 2 read, 3 enable write
  task automatic strobe(input int kind, input logic [1:0] sel, input logic [15:0] data);
    @(negedge ref_clk);
    reg_select = sel;
    enable_data = data;
    clear_status = (kind == 0);
    status_preset = (kind == 1);
    event_read = (kind == 2);
    enable_write = (kind == 3);
    @(negedge ref_clk);
    {clear_status, status_preset, event_read, enable_write} = 4'h0;
    // stale lines inverted so nothing relies on old values
    reg_select = ~sel;
    enable_data = ~data;
  endtask
  task automatic read_reg(input logic [1:0] sel, output logic [15:0] d);
    strobe(2, sel, 16'h0000);
    d = read_data_reg;
  endtask
  task automatic mask_all(input logic [1:0] sel);
    strobe(3, sel, 16'h0000);
  endtask
  task automatic wait_full(output logic [15:0] d, output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 64 && !ok; i++)
    begin
      read_reg(SEES_SET_MEAS, d);
      ok = d[SEES_BATT_BUF_FULL_BIT];
    end
  endtask
endmodule
`default_nettype wire

//--- tb/status_event_enable_summary_test.sv
// Purpose: self-checking bench for the status event and enable block
// Assumes: inputs change at the falling edge, seed fixed
// Notes: expectations tracked in xev and xen, never read back from the design
`timescale 1ns/1ps
`default_nettype none
module status_event_enable_summary_test;
  import sees_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] ev_i [4];
  logic [15:0] cond_i [3];
  logic buf_trigger, reading_done, err;
  logic [15:0] avg_count;
  logic [7:0] sre;
  logic clear_status, status_preset, event_read, enable_write;
  logic [1:0] reg_select;
  logic [15:0] enable_data, read_data_reg, d, old, nv;
  logic [15:0] ev_o [4];
  logic [15:0] en_o [4];
  logic [15:0] cond_o [3];
  logic [7:0] status_byte_reg;
  logic [15:0] xev [4];
  logic [15:0] xen [4];
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  int n;
  bit ok;
  always #2.5 ref_clk = ~ref_clk;
  sees_status_top i_sees_status_top (.ref_clk(ref_clk), .rst(rst),
    .std_event_in(ev_i[0]), .oper_event_in(ev_i[1]), .meas_event_in(ev_i[2]),
    .ques_event_in(ev_i[3]), .oper_cond_in(cond_i[0]), .meas_cond_in(cond_i[1]),
    .ques_cond_in(cond_i[2]), .buf_trigger(buf_trigger), .reading_done(reading_done),
    .avg_count(avg_count), .clear_status(clear_status), .status_preset(status_preset),
    .event_read(event_read), .enable_write(enable_write), .reg_select(reg_select),
    .enable_data(enable_data), .error_available_flag(err), .stb_enable(sre),
    .std_event_reg(ev_o[0]), .oper_event_reg(ev_o[1]), .meas_event_reg(ev_o[2]),
    .ques_event_reg(ev_o[3]), .std_enable_reg(en_o[0]), .oper_enable_reg(en_o[1]),
    .meas_enable_reg(en_o[2]), .ques_enable_reg(en_o[3]), .oper_cond_reg(cond_o[0]),
    .meas_cond_reg(cond_o[1]), .ques_cond_reg(cond_o[2]), .read_data_reg(read_data_reg),
    .status_byte_reg(status_byte_reg));
  sees_host_model i_sees_host_model (.ref_clk(ref_clk), .clear_status(clear_status),
    .status_preset(status_preset), .event_read(event_read), .enable_write(enable_write),
    .reg_select(reg_select), .enable_data(enable_data), .read_data_reg(read_data_reg));
  // ---------------------------------------------------------------
  // expectation and comparison
  // ---------------------------------------------------------------
  function automatic logic [7:0] stb_exp();
    logic [7:0] s;
    s = 8'h00;
    s[SEES_STB_STD_BIT] = |(xev[0] & xen[0]);
    s[SEES_STB_OPER_BIT] = |(xev[1] & xen[1]);
    s[SEES_STB_MEAS_BIT] = |(xev[2] & xen[2]);
    s[SEES_STB_QUES_BIT] = |(xev[3] & xen[3]);
    s[SEES_STB_ERR_AVAIL_BIT] = err;
    s[SEES_STB_MSS_BIT] = |(s & sre);
    return s;
  endfunction
  task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_all();
    repeat (3) @(negedge ref_clk);
    for (int i = 0; i < 4; i++)
    begin
      cmp16("event reg", xev[i], ev_o[i]);
      cmp16("enable reg", xen[i], en_o[i]);
    end
    cmp8("status byte", stb_exp(), status_byte_reg);
  endtask
  task automatic pulse_ev(input int s, input logic [15:0] v);
    @(negedge ref_clk);
    ev_i[s] = v;
    @(negedge ref_clk);
    ev_i[s] = 16'h0000;
    xev[s] = xev[s] | v;
  endtask
  task automatic pulse(ref logic sig);
    @(negedge ref_clk);
    sig = 1'b1;
    @(negedge ref_clk);
    sig = 1'b0;
  endtask
  task automatic fill_all();
    for (int s = 0; s < 4; s++)
    begin
      xen[s] = 16'($urandom);
      i_sees_host_model.strobe(3, s[1:0], xen[s]);
      pulse_ev(s, 16'($urandom));
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // runaway guard, tests need a few hundred cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      results();
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 4; i++)
    begin
      ev_i[i] = 16'h0000;
      xev[i] = 16'h0000;
      xen[i] = 16'h0000;
    end
    for (int i = 0; i < 3; i++)
      cond_i[i] = 16'h0000;
    {buf_trigger, reading_done, err} = 3'h0;
    avg_count = 16'h0000;
    sre = 8'h00;
    n = $urandom(32'h0a23);
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    check_all();
    for (int r = 0; r < 3; r++)
      for (int s = 0; s < 4; s++)
      begin
        err = 1'($urandom);
        sre = 8'($urandom);
        xen[s] = 16'($urandom);
        i_sees_host_model.strobe(3, s[1:0], xen[s]);
        pulse_ev(s, 16'($urandom));
        check_all();
        i_sees_host_model.read_reg(s[1:0], d);
        cmp16("read data", xev[s], d);
        xev[s] = 16'h0000;
        check_all();
      end
    fill_all();
    i_sees_host_model.strobe(0, 2'h0, 16'h0000);
    for (int s = 0; s < 4; s++)
      xev[s] = 16'h0000;
    check_all();
    fill_all();
    i_sees_host_model.strobe(1, 2'h0, 16'h0000);
    for (int s = 1; s < 4; s++)
      xen[s] = 16'h0000;
    check_all();
    i_sees_host_model.mask_all(SEES_SET_STD);
    xen[0] = 16'h0000;
    check_all();
    old = xev[2];
    nv = 16'h8000 >> ($urandom % 16);
    fork
      i_sees_host_model.read_reg(SEES_SET_MEAS, d);
      pulse_ev(2, nv);
    join
    cmp16("read during event", old, d);
    // clear empties old bits, new event survives even if it was already set
    xev[2] = nv;
    check_all();
    // three passes, zero count acts as one
    xen[2] = 16'h0200;
    i_sees_host_model.strobe(3, SEES_SET_MEAS, 16'h0200);
    // empty stale bits so an old bit nine cannot end the poll early
    i_sees_host_model.read_reg(SEES_SET_MEAS, d);
    cmp16("meas before fill", xev[2], d);
    xev[2] = 16'h0000;
    for (int a = 0; a < 3; a++)
    begin
      avg_count = (a == 0) ? 16'h0000 : 16'(($urandom % 8) + 1);
      n = (a == 0) ? 1 : int'(avg_count);
      pulse(buf_trigger);
      fork
        for (int k = 0; k < n; k++)
        begin
          if (k == n - 1)
          begin
            repeat (3) @(negedge ref_clk);
            cmp16("early full", 16'h0000, ev_o[2] & 16'h0200);
          end
          pulse(reading_done);
        end
        i_sees_host_model.wait_full(d, ok);
      join
      cmp16("full read", 16'h0200, d);
      xev[2] = 16'h0000;
      check_all();
    end
    for (int r = 0; r < 4; r++)
    begin
      @(negedge ref_clk);
      for (int i = 0; i < 3; i++)
        cond_i[i] = 16'($urandom);
      @(negedge ref_clk);
      for (int i = 0; i < 3; i++)
        cmp16("condition reg", cond_i[i], cond_o[i]);
    end
    results();
  end
endmodule
`default_nettype wire
